// [design/mcr_pkg.sv]
// How it works
// - Each transfer opens with an eight-bit command byte from the host.
// - Command bits 4..0 give the register index for the data bits of the same transfer.
// - Command bit 7 high means write, low means read.
// - Mode bit 0 bypasses the first channel high-pass filter.
// - Mode bit 2 stops the frequency output; bit 3 stops dip detection.
// - Writing mode bit 6 resets the whole chip.
// - Mode bit 7 selects calibration mode.
// - Mode bits 8 and 9 short the first and second converter inputs.
// - Mode bit 10 swaps the two analog input pairs.
// - Mode bits 12..11 pick waveform rate: clock over 128, 256, 512, 1024.
// - Mode bits 14..13 pick waveform source: power, reserved, channel 1, 2.
// - Events set their flag; interrupt drives low only if enabled.
// - Flag 0 sets on energy msb rising from zero to one.
// - Flag 1 sets on dip or lost crossings, or calibration end while mode bit 7 is set.
// - Flag 3 marks new waveform data; flag 5 new temperature result.
// - Flag 4 follows the zero-crossing level, not latched.
// - Flag 7 sets when the energy register overflows.
// - Reading the clearing alias returns the flags and clears them.
// - A disabled interrupt still sets its flag without driving the request.
package mcr_pkg;
    localparam logic [4:0]  A_STATUS     = 5'h04;
    localparam logic [4:0]  A_STATUS_CLR = 5'h05;
    localparam logic [4:0]  A_MODE       = 5'h06;
    localparam logic [4:0]  CMD_LAST     = 5'h07;
    localparam int          CMD_RW       = 7;
    localparam logic [4:0]  LEN_BYTE     = 5'h08;
    localparam logic [4:0]  LEN_WORD     = 5'h10;
    localparam int          M_HPF        = 0;
    localparam int          M_FREQ_OFF   = 2;
    localparam int          M_DIP_OFF    = 3;
    localparam int          M_SOFT       = 6;
    localparam int          M_CAL        = 7;
    localparam int          M_SH1        = 8;
    localparam int          M_SH2        = 9;
    localparam int          M_SWAP       = 10;
    localparam int          M_RATE       = 11;
    localparam int          M_SRC        = 13;
    localparam logic [15:0] MODE_RST     = 16'h0000;
    localparam int          F_HALF       = 0;
    localparam int          F_DIP        = 1;
    localparam int          F_RES_A      = 2;
    localparam int          F_WAVE       = 3;
    localparam int          F_ZX         = 4;
    localparam int          F_TEMP       = 5;
    localparam int          F_RES_B      = 6;
    localparam int          F_OVF        = 7;
    localparam logic [7:0]  FLAG_RST     = 8'h00;
    localparam logic [7:0]  FLAG_LATCH   = 8'hab;
    localparam logic [9:0]  WAVE_T128    = 10'h07f;
    localparam logic [9:0]  WAVE_T256    = 10'h0ff;
    localparam logic [9:0]  WAVE_T512    = 10'h1ff;
    localparam logic [9:0]  WAVE_T1024   = 10'h3ff;

    typedef enum logic [1:0] {
        MCR_CMD = 2'b00,
        MCR_RD  = 2'b01,
        MCR_WR  = 2'b10
    } mcr_phase_e;

    typedef struct packed {
        logic energy_msb;
        logic dip;
        logic cal_end;
        logic temp;
        logic zero_cross;
        logic overflow;
    } mcr_evt_s;

    typedef struct packed {
        logic [1:0] waveform_source_select;
        logic [1:0] waveform_rate_select;
        logic       swap_inputs;
        logic       short_second_inputs;
        logic       short_first_inputs;
        logic       calibration_select;
        logic       dip_detect_off;
        logic       freq_output_off;
        logic       highpass_bypass;
    } mcr_cfg_s;

    typedef struct packed {
        logic [15:0] mode;
        logic [7:0]  flags;
        logic [23:0] shadow;
        logic        msb_q;
        logic        cs_s1;
        logic        cs_s2;
        logic        w_s1;
        logic        w_s2;
        logic        w_s3;
        logic        c_s1;
        logic        c_s2;
        logic        c_s3;
        logic [9:0]  wv_cnt;
        logic        wave_q;
        logic        soft_q;
        logic        irq_q;
    } mcr_core_s;

    typedef struct packed {
        mcr_phase_e  ph;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic [4:0]  addr;
        logic [15:0] tx;
    } mcr_link_s;

    typedef struct packed {
        logic        wtog;
        logic        ctog;
        logic [4:0]  waddr;
        logic [15:0] wdata;
    } mcr_tog_s;
endpackage

// [design/mcr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module mcr_regs (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Serial port, link clock domain
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              din,
    output logic                   dout,
    output logic                   dout_en_n,
    // Measurement events and enables
    input  wire mcr_pkg::mcr_evt_s evt,
    input  wire logic [7:0]        irq_enable,
    // Configuration and strobes
    output mcr_pkg::mcr_cfg_s      cfg,
    output logic                   wave_update,
    output logic                   soft_chip_reset,
    // Open-drain interrupt request
    output logic                   irq_n_out,
    output logic                   irq_drive_n
);
    mcr_pkg::mcr_core_s c_q;
    mcr_pkg::mcr_core_s c_d;
    mcr_pkg::mcr_link_s l_q;
    mcr_pkg::mcr_link_s l_d;
    mcr_pkg::mcr_tog_s  t_q;
    mcr_pkg::mcr_tog_s  t_d;
    logic               frame_rst_n;
    logic               wr_hit;
    logic               clr_hit;
    logic               soft_now;
    logic [7:0]         set_v;
    logic [7:0]         clr_v;
    logic [15:0]        cmd_v;

    // Data bits carried by each register
    function automatic logic [4:0] reg_len(input logic [4:0] a);
        reg_len = (a == mcr_pkg::A_MODE) ? mcr_pkg::LEN_WORD : mcr_pkg::LEN_BYTE;
    endfunction

    // Waveform update period, last count
    function automatic logic [9:0] wave_term(input logic [1:0] r);
        case (r)
            2'h0:    wave_term = mcr_pkg::WAVE_T128;
            2'h1:    wave_term = mcr_pkg::WAVE_T256;
            2'h2:    wave_term = mcr_pkg::WAVE_T512;
            default: wave_term = mcr_pkg::WAVE_T1024;
        endcase
    endfunction

    // Read word, left aligned for msb-first shifting
    function automatic logic [15:0] read_word(input logic [4:0] a, input logic [23:0] s);
        case (a)
            mcr_pkg::A_STATUS:     read_word = {s[23:16], 8'h00};
            mcr_pkg::A_STATUS_CLR: read_word = {s[23:16], 8'h00};
            mcr_pkg::A_MODE:       read_word = s[15:0];
            default:               read_word = 16'h0000;
        endcase
    endfunction

    assign frame_rst_n = reset_n & ~cs_n;

    // Core domain
    always_comb
    begin
        c_d        = c_q;
        c_d.cs_s1  = cs_n;
        c_d.cs_s2  = c_q.cs_s1;
        c_d.w_s1   = t_q.wtog;
        c_d.w_s2   = c_q.w_s1;
        c_d.w_s3   = c_q.w_s2;
        c_d.c_s1   = t_q.ctog;
        c_d.c_s2   = c_q.c_s1;
        c_d.c_s3   = c_q.c_s2;
        c_d.msb_q  = evt.energy_msb;
        wr_hit     = c_q.w_s2 ^ c_q.w_s3;
        clr_hit    = c_q.c_s2 ^ c_q.c_s3;
        soft_now   = wr_hit && (t_q.waddr == mcr_pkg::A_MODE) && t_q.wdata[mcr_pkg::M_SOFT];
        set_v      = 8'h00;
        set_v[mcr_pkg::F_HALF] = evt.energy_msb & ~c_q.msb_q;
        set_v[mcr_pkg::F_DIP]  = evt.dip | (evt.cal_end & c_q.mode[mcr_pkg::M_CAL]);
        set_v[mcr_pkg::F_WAVE] = c_q.wave_q;
        set_v[mcr_pkg::F_TEMP] = evt.temp;
        set_v[mcr_pkg::F_OVF]  = evt.overflow;
        // Clear only what the alias read returned; a new event still wins
        clr_v      = clr_hit ? c_q.shadow[23:16] : 8'h00;
        c_d.flags  = ((c_q.flags & ~clr_v) | set_v) & mcr_pkg::FLAG_LATCH;
        // Waveform update strobe
        if (c_q.wv_cnt == wave_term(c_q.mode[mcr_pkg::M_RATE +: 2]))
        begin
            c_d.wv_cnt = 10'h000;
            c_d.wave_q = 1'b1;
        end
        else
        begin
            c_d.wv_cnt = c_q.wv_cnt + 10'h001;
            c_d.wave_q = 1'b0;
        end
        c_d.soft_q = 1'b0;
        if (wr_hit && (t_q.waddr == mcr_pkg::A_MODE))
        begin
            if (soft_now)
            begin
                c_d.mode   = mcr_pkg::MODE_RST;
                c_d.flags  = mcr_pkg::FLAG_RST;
                c_d.wv_cnt = 10'h000;
                c_d.soft_q = 1'b1;
            end
            else
            begin
                c_d.mode = t_q.wdata;
            end
        end
        // Level mirror survives a soft reset
        c_d.flags[mcr_pkg::F_ZX] = evt.zero_cross;
        // Snapshot held still while a frame runs
        if (c_q.cs_s2)
        begin
            c_d.shadow = {c_q.flags, c_q.mode};
        end
        c_d.irq_q = |(c_q.flags & irq_enable);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            c_q        <= '0;
            c_q.cs_s1  <= 1'b1;
            c_q.cs_s2  <= 1'b1;
            c_q.mode   <= mcr_pkg::MODE_RST;
            c_q.flags  <= mcr_pkg::FLAG_RST;
        end
        else
        begin
            c_q <= c_d;
        end
    end

    // Link domain
    always_comb
    begin
        l_d   = l_q;
        t_d   = t_q;
        cmd_v = {l_q.sh[14:0], din};
        case (l_q.ph)
            mcr_pkg::MCR_CMD:
            begin
                l_d.sh  = cmd_v;
                l_d.cnt = l_q.cnt + 5'h01;
                if (l_q.cnt == mcr_pkg::CMD_LAST)
                begin
                    l_d.cnt  = 5'h00;
                    l_d.addr = cmd_v[4:0];
                    if (cmd_v[mcr_pkg::CMD_RW])
                    begin
                        l_d.ph = mcr_pkg::MCR_WR;
                    end
                    else
                    begin
                        l_d.ph = mcr_pkg::MCR_RD;
                        l_d.tx = read_word(cmd_v[4:0], c_q.shadow);
                        if (cmd_v[4:0] == mcr_pkg::A_STATUS_CLR)
                        begin
                            t_d.ctog = ~t_q.ctog;
                        end
                    end
                end
            end
            mcr_pkg::MCR_RD:
            begin
                l_d.tx  = {l_q.tx[14:0], 1'b0};
                l_d.cnt = l_q.cnt + 5'h01;
                if (l_q.cnt == reg_len(l_q.addr) - 5'h01)
                begin
                    l_d.ph  = mcr_pkg::MCR_CMD;
                    l_d.cnt = 5'h00;
                end
            end
            mcr_pkg::MCR_WR:
            begin
                l_d.sh  = cmd_v;
                l_d.cnt = l_q.cnt + 5'h01;
                if (l_q.cnt == reg_len(l_q.addr) - 5'h01)
                begin
                    l_d.ph    = mcr_pkg::MCR_CMD;
                    l_d.cnt   = 5'h00;
                    t_d.waddr = l_q.addr;
                    t_d.wdata = (reg_len(l_q.addr) == mcr_pkg::LEN_WORD) ? cmd_v
                              : {8'h00, cmd_v[7:0]};
                    t_d.wtog  = ~t_q.wtog;
                end
            end
            default:
            begin
                l_d.ph = mcr_pkg::MCR_CMD;
            end
        endcase
    end

    // Frame state restarts whenever the select is high
    always_ff @(posedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            l_q <= '0;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    // Handover words survive between frames
    always_ff @(posedge sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            t_q <= '0;
        end
        else
        begin
            t_q <= t_d;
        end
    end

    // Outputs
    assign dout            = l_q.tx[15];
    assign dout_en_n       = (l_q.ph != mcr_pkg::MCR_RD);
    assign wave_update     = c_q.wave_q;
    assign soft_chip_reset = c_q.soft_q;
    assign irq_n_out       = 1'b0;
    assign irq_drive_n     = ~c_q.irq_q;
    assign cfg.highpass_bypass        = c_q.mode[mcr_pkg::M_HPF];
    assign cfg.freq_output_off        = c_q.mode[mcr_pkg::M_FREQ_OFF];
    assign cfg.dip_detect_off         = c_q.mode[mcr_pkg::M_DIP_OFF];
    assign cfg.calibration_select     = c_q.mode[mcr_pkg::M_CAL];
    assign cfg.short_first_inputs     = c_q.mode[mcr_pkg::M_SH1];
    assign cfg.short_second_inputs    = c_q.mode[mcr_pkg::M_SH2];
    assign cfg.swap_inputs            = c_q.mode[mcr_pkg::M_SWAP];
    assign cfg.waveform_rate_select   = c_q.mode[mcr_pkg::M_RATE +: 2];
    assign cfg.waveform_source_select = c_q.mode[mcr_pkg::M_SRC +: 2];

    // Checks
    sequence s_soft_write;
        soft_now;
    endsequence

    sequence s_wave_gap;
        !c_q.wave_q [*8];
    endsequence

    a_half_flag_edge: assert property (@(posedge clk) disable iff (!reset_n)
        (evt.energy_msb && !c_q.msb_q && !soft_now) |=> c_q.flags[mcr_pkg::F_HALF])
        else $error("energy half flag not set");

    a_dip_cal_end: assert property (@(posedge clk) disable iff (!reset_n)
        (evt.cal_end && c_q.mode[mcr_pkg::M_CAL] && !soft_now) |=> c_q.flags[mcr_pkg::F_DIP])
        else $error("calibration end not flagged");

    a_wave_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
        (c_q.wave_q && !soft_now) |=> c_q.flags[mcr_pkg::F_WAVE])
        else $error("waveform flag not set");

    a_wave_rate_gap: assert property (@(posedge clk) disable iff (!reset_n)
        c_q.wave_q |=> s_wave_gap)
        else $error("waveform strobes too close");

    a_zx_mirror_level: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> (c_q.flags[mcr_pkg::F_ZX] == $past(evt.zero_cross)))
        else $error("zero cross flag not mirrored");

    a_ovf_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
        (evt.overflow && !soft_now) |=> c_q.flags[mcr_pkg::F_OVF])
        else $error("overflow flag not set");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
        !c_q.flags[mcr_pkg::F_RES_A] && !c_q.flags[mcr_pkg::F_RES_B])
        else $error("reserved flag bit set");

    a_irq_enable_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (|(c_q.flags & irq_enable)) |=> !irq_drive_n)
        else $error("enabled flag without request");

    a_irq_disabled_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        ((c_q.flags & irq_enable) == 8'h00) |=> irq_drive_n)
        else $error("request without enabled flag");

    a_soft_reset_seq: assert property (@(posedge clk) disable iff (!reset_n)
        s_soft_write |=> (soft_chip_reset && c_q.mode == mcr_pkg::MODE_RST) ##1 !soft_chip_reset)
        else $error("soft reset sequence wrong");

    a_clear_on_read: assert property (@(posedge clk) disable iff (!reset_n)
        (clr_hit && !soft_now) |=>
        ((c_q.flags & $past(c_q.shadow[23:16]) & ~$past(set_v) & mcr_pkg::FLAG_LATCH) == 8'h00))
        else $error("alias read did not clear flags");

    a_read_drives: assert property (@(posedge sclk) disable iff (!frame_rst_n)
        (l_q.ph == mcr_pkg::MCR_CMD && l_q.cnt == mcr_pkg::CMD_LAST && !l_q.sh[6])
        |=> !dout_en_n)
        else $error("read command did not drive output");

    a_write_quiet: assert property (@(posedge sclk) disable iff (!frame_rst_n)
        (l_q.ph == mcr_pkg::MCR_CMD && l_q.cnt == mcr_pkg::CMD_LAST && l_q.sh[6])
        |=> (dout_en_n && l_q.ph == mcr_pkg::MCR_WR))
        else $error("write command mishandled");

    a_dip_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
        (evt.dip && !soft_now) |=> c_q.flags[mcr_pkg::F_DIP])
        else $error("dip flag not set");

    a_temp_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
        (evt.temp && !soft_now) |=> c_q.flags[mcr_pkg::F_TEMP])
        else $error("temperature flag not set");

    a_mode_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_hit && t_q.waddr == mcr_pkg::A_MODE && !soft_now)
        |=> (c_q.mode == $past(t_q.wdata)))
        else $error("mode write lost");

    a_soft_flags_zero: assert property (@(posedge clk) disable iff (!reset_n)
        s_soft_write |=> ((c_q.flags & mcr_pkg::FLAG_LATCH) == 8'h00))
        else $error("soft reset left flags set");

    a_index_capture: assert property (@(posedge sclk) disable iff (!frame_rst_n)
        (l_q.ph == mcr_pkg::MCR_CMD && l_q.cnt == mcr_pkg::CMD_LAST)
        |=> (l_q.addr == $past({l_q.sh[3:0], din})))
        else $error("register index not captured");
endmodule
`default_nettype wire

// [tb/mcr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module mcr_host (
    // Serial port toward the device
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_en_n
);
    logic drive_ok;

    initial
    begin
        sclk     = 1'b0;
        cs_n     = 1'b1;
        din      = 1'b0;
        drive_ok = 1'b1;
    end

    // One frame: command byte, then the data bits of the addressed register
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [4:0]  len;
        logic [15:0] w;
        logic [23:0] bits;
        len  = (cmd[4:0] == mcr_pkg::A_MODE) ? 5'h10 : 5'h08;
        w    = (len == 5'h10) ? (wd & 16'h7fcd) : {wd[7:0], 8'h00};
        bits = {cmd & 8'h9f, w};
        rd   = 16'h0000;
        #7 cs_n = 1'b0;
        // Let the device freeze its read snapshot first
        #120;
        for (int i = 0; i < 8 + int'(len); i++)
        begin
            din = bits[23 - i];
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
            if (!cmd[7] && i >= 7 && i < 7 + int'(len))
            begin
                rd = {rd[14:0], dout};
                if (dout_en_n !== 1'b0)
                    drive_ok = 1'b0;
            end
        end
        #15;
        if (dout_en_n !== 1'b1)
            drive_ok = 1'b0;
        cs_n = 1'b1;
        // Idle data line does not keep its last value
        din  = ~din;
        #100;
        if (cmd[7])
            #4000;
        if (cmd[7] && len == 5'h10 && w[6])
            #18000;
    endtask
endmodule
`default_nettype wire

// [tb/metering_control_registers_test.sv]
`timescale 1ns/1ps
`default_nettype none
module metering_control_registers_test;
    logic              clk;
    logic              reset_n;
    logic              sclk;
    logic              cs_n;
    logic              din;
    logic              dout;
    logic              dout_en_n;
    mcr_pkg::mcr_evt_s evt;
    logic [7:0]        irq_enable;
    mcr_pkg::mcr_cfg_s cfg;
    logic              wave_update;
    logic              soft_chip_reset;
    logic              irq_n_out;
    logic              irq_drive_n;
    logic              irq_line;
    int                mismatches;
    int                checked;
    int                soft_cnt;
    logic [15:0]       modes [8];
    logic [5:0]        evs [5];
    logic [7:0]        fl [5];

    // Open-drain request line with pull-up
    assign irq_line = irq_drive_n ? 1'b1 : irq_n_out;

    mcr_regs uut (
        .clk             (clk),
        .reset_n         (reset_n),
        .sclk            (sclk),
        .cs_n            (cs_n),
        .din             (din),
        .dout            (dout),
        .dout_en_n       (dout_en_n),
        .evt             (evt),
        .irq_enable      (irq_enable),
        .cfg             (cfg),
        .wave_update     (wave_update),
        .soft_chip_reset (soft_chip_reset),
        .irq_n_out       (irq_n_out),
        .irq_drive_n     (irq_drive_n)
    );

    mcr_host host (
        .sclk      (sclk),
        .cs_n      (cs_n),
        .din       (din),
        .dout      (dout),
        .dout_en_n (dout_en_n)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("mismatches %0d, checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        host.xfer({3'b000, a}, 16'h0000, v);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        logic [15:0] dummy;
        host.xfer({3'b100, a}, v, dummy);
    endtask

    task automatic pulse(input logic [5:0] e);
        @(posedge clk) evt <= e;
        @(posedge clk) evt <= 6'h00;
    endtask

    // Clock count between two waveform strobes, skipping the first two gaps
    task automatic wave_gap(output int n);
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while (wave_update !== 1'b1 && n < 2100);
            if (n >= 2100)
            begin
                mismatches++;
                test_done();
            end
        end
    endtask

    function automatic logic [10:0] exp_cfg(input logic [15:0] m);
        return {m[14:13], m[12:11], m[10], m[9], m[8], m[7], m[3], m[2], m[0]};
    endfunction

    always @(posedge clk)
        if (soft_chip_reset === 1'b1)
            soft_cnt++;

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial
    begin
        logic [15:0] v;
        int          n;
        modes = '{16'h0001, 16'h2004, 16'h0888, 16'h4100,
                  16'h1200, 16'h6400, 16'h1800, 16'h0000};
        evs = '{6'h20, 6'h10, 6'h04, 6'h01, 6'h08};
        fl = '{8'h01, 8'h02, 8'h20, 8'h80, 8'h02};
        mismatches = 0;
        checked = 0;
        soft_cnt = 0;
        reset_n = 1'b0;
        evt = 6'h00;
        irq_enable = 8'h00;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Power-on state
        rd(mcr_pkg::A_STATUS, v);
        check("flags at reset", v & 16'h00f7, 16'h0000);
        rd(mcr_pkg::A_MODE, v);
        check("mode at reset", v, 16'h0000);
        // Every configuration field, rate and source code
        for (int i = 0; i < 8; i++)
        begin
            wr(mcr_pkg::A_MODE, modes[i]);
            check("cfg", {5'h00, cfg}, {5'h00, exp_cfg(modes[i])});
            rd(mcr_pkg::A_MODE, v);
            check("mode", v, modes[i]);
            wave_gap(n);
            check("wave period", n[15:0], 16'(128 << modes[i][12:11]));
        end
        // Latched events, plain and clearing reads
        for (int i = 0; i < 5; i++)
        begin
            if (i == 4)
                wr(mcr_pkg::A_MODE, 16'h0080);
            pulse(evs[i]);
            rd(mcr_pkg::A_STATUS, v);
            check("flags", v & 16'h00f7, {8'h00, fl[i]});
            rd(mcr_pkg::A_STATUS_CLR, v);
            check("clear read", v & 16'h00f7, {8'h00, fl[i]});
            rd(mcr_pkg::A_STATUS, v);
            check("after clear", v & 16'h00f7, 16'h0000);
        end
        repeat (1100) @(posedge clk);
        rd(mcr_pkg::A_STATUS, v);
        check("wave flag", v & 16'h0008, 16'h0008);
        // Zero-crossing mirror
        @(posedge clk) evt.zero_cross <= 1'b1;
        rd(mcr_pkg::A_STATUS_CLR, v);
        check("zx set", v & 16'h0010, 16'h0010);
        rd(mcr_pkg::A_STATUS, v);
        check("zx kept", v & 16'h0010, 16'h0010);
        @(posedge clk) evt.zero_cross <= 1'b0;
        rd(mcr_pkg::A_STATUS, v);
        check("zx low", v & 16'h0010, 16'h0000);
        // Interrupt request, disabled then enabled
        pulse(6'h01);
        repeat (4) @(negedge clk);
        check("irq disabled", {15'h0000, irq_line}, 16'h0001);
        rd(mcr_pkg::A_STATUS, v);
        check("flag disabled", v & 16'h0080, 16'h0080);
        @(posedge clk) irq_enable <= 8'h80;
        repeat (3) @(negedge clk);
        check("irq enabled", {15'h0000, irq_line}, 16'h0000);
        rd(mcr_pkg::A_STATUS_CLR, v);
        check("irq source", v & 16'h0080, 16'h0080);
        repeat (3) @(negedge clk);
        check("irq cleared", {15'h0000, irq_line}, 16'h0001);
        // Index outside this block
        wr(5'h07, 16'h00ff);
        rd(mcr_pkg::A_MODE, v);
        check("mode kept", v, 16'h0080);
        rd(5'h07, v);
        check("other index", v, 16'h0000);
        // Software reset
        pulse(6'h01);
        wr(mcr_pkg::A_MODE, 16'h0041);
        check("soft pulses", soft_cnt[15:0], 16'h0001);
        check("cfg after soft", {5'h00, cfg}, 16'h0000);
        rd(mcr_pkg::A_MODE, v);
        check("mode after soft", v, 16'h0000);
        rd(mcr_pkg::A_STATUS, v);
        check("flags after soft", v & 16'h00f7, 16'h0000);
        check("read drive", {15'h0000, host.drive_ok}, 16'h0001);
        test_done();
    end
endmodule
`default_nettype wire
